// File: design/malt_age_if.sv
// Purpose: Aging scan request between period timer and table engine
// Assumes: One clock domain
// Notes: req holds until the engine returns a one-cycle ack
`timescale 1ns/100ps
interface malt_age_if;
  logic req;
  logic ack;
  modport timer (output req, input ack);
  modport engine (input req, output ack);
endinterface : malt_age_if

// File: design/malt_age_timer.sv
// Purpose: Raises an aging scan request once per aging period
// Assumes: P_CYCLES of at least two
// Notes: A period elapsing while a scan is still asked for is merged into it
`timescale 1ns/100ps
module malt_age_timer #(
  parameter logic [malt_pkg::AGE_CNT_W-1:0] P_CYCLES = malt_pkg::AGE_CYCLES[malt_pkg::AGE_CNT_W-1:0]
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  malt_age_if.timer age
);

  logic [malt_pkg::AGE_CNT_W-1:0] cnt_r;
  logic [malt_pkg::AGE_CNT_W-1:0] cnt_nxt;
  logic req_r;
  logic req_nxt;
  logic expire;

  always_comb begin
    expire = (cnt_r == P_CYCLES - 1'b1);
    cnt_nxt = expire ? '0 : cnt_r + 1'b1;
    // Set wins over the acknowledge
    req_nxt = (req_r && !age.ack) || expire;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cnt_r <= '0;
      req_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
    end
  end

  assign age.req = req_r;

  property p_age_period;
    @(posedge mclk_i) disable iff (srst_i)
      $rose(req_r) |-> $past(cnt_r) == P_CYCLES - 1'b1;
  endproperty
  a_age_period: assert property (p_age_period) else $error("aging request off period");

endmodule : malt_age_timer

// File: design/malt_engine.sv
// Purpose: MAC address table with lookup, learning, aging and host access
// Assumes: Ingress inputs synchronous to mclk_i; Avalon-MM register slave
// Notes: Direct-mapped table indexed by a fold of the MAC address
//
// Behaviour
// - Table holds 1024 entries, searched per destination
// - Match returns ports, filter, priority, override
// - Entry is 57 bits with fixed fields
// - Unknown source address learned with receive port
// - Known source refreshed: port updated, age set
// - Per-port learning enable gates add and refresh
// - Scan clears age bit or removes entry
// - Aging scan repeats about every five minutes
// - Static entries never aged nor changed by learning
// - Port field may name several ports
// - Filter flag on match filters the packet
// - Static plus age overrides spanning tree state
// - Static entry priority used when enabled
// - Valid and static both zero deletes entry
// - Make pending held until table write done
// - Get first starts walk; host polls result
// - Read data hold entry or end of table
// - Get next presents following entry or end
// - Walk order need not match learning order
`timescale 1ns/100ps
module malt_engine #(
  parameter logic [malt_pkg::AGE_CNT_W-1:0] P_AGE_CYCLES = malt_pkg::AGE_CYCLES[malt_pkg::AGE_CNT_W-1:0]
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [47:0] in_sa_i,
  input wire logic [47:0] in_da_i,
  input wire logic [1:0] in_port_i,
  output logic lk_valid_o,
  output logic lk_hit_o,
  output logic [2:0] lk_ports_o,
  output logic lk_filter_o,
  output logic [1:0] lk_prio_o,
  output logic lk_prio_use_o,
  output logic lk_stp_override_o
);

  localparam int unsigned EW = malt_pkg::ENT_W;
  localparam int unsigned IW = malt_pkg::IDX_W;
  localparam int unsigned MW = malt_pkg::MAC_W;
  localparam int unsigned HW = malt_pkg::HI_W;

  malt_age_if age_if ();

  malt_age_timer #(.P_CYCLES(P_AGE_CYCLES)) u_age_timer (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .age(age_if.timer)
  );

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [2:0] cmd_r, cmd_nxt, cmd_prev_r;
  logic [31:0] wr_lo_r, wr_lo_nxt;
  logic [HW-1:0] wr_hi_r, wr_hi_nxt;
  logic [0:0] gcfg_r, gcfg_nxt;
  logic [2:0] pcfg_r, pcfg_nxt;
  logic [2:0] cmd_rise;
  logic bus_req, bus_acc;
  logic [31:0] wmerge, rmux;
  logic make_pend_r;
  logic [EW-1:0] rd_e_r;
  logic eot_r;

  always_comb begin
    bus_req = avs_read_i || avs_write_i;
    bus_acc = bus_req && !wait_r;
    // One wait state: request seen, then answered at the next edge
    wait_nxt = !(bus_req && wait_r);
    cmd_rise = cmd_r & ~cmd_prev_r;
    case (avs_address_i)
      malt_pkg::OFF_CMD: rmux = {29'h0, cmd_r};
      malt_pkg::OFF_STS: rmux = {31'h0, make_pend_r};
      malt_pkg::OFF_WR_LO: rmux = wr_lo_r;
      malt_pkg::OFF_WR_HI: rmux = {7'h0, wr_hi_r};
      malt_pkg::OFF_RD_LO: rmux = rd_e_r[31:0];
      malt_pkg::OFF_RD_HI: rmux = {6'h0, eot_r, rd_e_r[EW-1:32]};
      malt_pkg::OFF_GCFG: rmux = {31'h0, gcfg_r};
      malt_pkg::OFF_PCFG: rmux = {29'h0, pcfg_r};
      default: rmux = 32'h0000_0000;
    endcase
    rdata_nxt = (avs_read_i && wait_r) ? rmux : rdata_r;
    cmd_nxt = cmd_r;
    wr_lo_nxt = wr_lo_r;
    wr_hi_nxt = wr_hi_r;
    gcfg_nxt = gcfg_r;
    pcfg_nxt = pcfg_r;
    wmerge = 32'h0000_0000;
    if (avs_write_i && bus_acc) begin
      case (avs_address_i)
        malt_pkg::OFF_CMD: begin
          wmerge = malt_pkg::malt_be_merge({29'h0, cmd_r}, avs_writedata_i, avs_byteenable_i);
          cmd_nxt = wmerge[2:0];
        end
        malt_pkg::OFF_WR_LO: begin
          wr_lo_nxt = malt_pkg::malt_be_merge(wr_lo_r, avs_writedata_i, avs_byteenable_i);
        end
        malt_pkg::OFF_WR_HI: begin
          wmerge = malt_pkg::malt_be_merge({7'h0, wr_hi_r}, avs_writedata_i, avs_byteenable_i);
          wr_hi_nxt = wmerge[HW-1:0];
        end
        malt_pkg::OFF_GCFG: begin
          wmerge = malt_pkg::malt_be_merge({31'h0, gcfg_r}, avs_writedata_i, avs_byteenable_i);
          gcfg_nxt = wmerge[0:0];
        end
        malt_pkg::OFF_PCFG: begin
          wmerge = malt_pkg::malt_be_merge({29'h0, pcfg_r}, avs_writedata_i, avs_byteenable_i);
          pcfg_nxt = wmerge[2:0];
        end
        default: wmerge = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wait_r <= 1'b1;
      rdata_r <= '0;
      cmd_r <= '0;
      cmd_prev_r <= '0;
      wr_lo_r <= '0;
      wr_hi_r <= '0;
      gcfg_r <= '0;
      pcfg_r <= malt_pkg::PCFG_RST;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      cmd_r <= cmd_nxt;
      cmd_prev_r <= cmd_r;
      wr_lo_r <= wr_lo_nxt;
      wr_hi_r <= wr_hi_nxt;
      gcfg_r <= gcfg_nxt;
      pcfg_r <= pcfg_nxt;
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  // ----------------------------------------------------------------
  // Table storage
  // ----------------------------------------------------------------
  logic [EW-1:0] tab_r [malt_pkg::TAB_DEPTH];
  logic tab_we;
  logic [IW-1:0] tab_widx;
  logic [EW-1:0] tab_wdata;

  for (genvar g = 0; g < malt_pkg::TAB_DEPTH; g++) begin : g_tab
    always_ff @(posedge mclk_i) begin
      if (srst_i) begin
        tab_r[g] <= '0;
      end else if (tab_we && tab_widx == IW'(g)) begin
        tab_r[g] <= tab_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Engine
  // ----------------------------------------------------------------
  malt_pkg::malt_state_e state_r, state_nxt;
  logic [MW-1:0] sa_r, sa_nxt, da_r, da_nxt;
  logic [1:0] port_r, port_nxt;
  logic in_ready_r, in_ready_nxt;
  logic make_pend_nxt, walk_req_r, walk_req_nxt;
  logic [IW:0] cur_r, cur_nxt;
  logic [IW-1:0] age_idx_r, age_idx_nxt, rd_idx;
  logic [EW-1:0] rd_e_nxt, cur_e, wr_e;
  logic eot_nxt;
  logic lk_valid_r, lk_valid_nxt, lk_hit_r, lk_hit_nxt, lk_filter_r, lk_filter_nxt;
  logic [2:0] lk_ports_r, lk_ports_nxt;
  logic [1:0] lk_prio_r, lk_prio_nxt;
  logic lk_puse_r, lk_puse_nxt, lk_ovr_r, lk_ovr_nxt;
  logic hit, learn_ok, age_ack;
  logic [MW-1:0] hit_key;

  always_comb begin
    wr_e = {wr_hi_r, wr_lo_r};
    case (state_r)
      malt_pkg::ST_LOOKUP: rd_idx = malt_pkg::malt_hash(da_r);
      malt_pkg::ST_LEARN: rd_idx = malt_pkg::malt_hash(sa_r);
      malt_pkg::ST_MAKE: rd_idx = malt_pkg::malt_hash(wr_e[MW-1:0]);
      malt_pkg::ST_WALK: rd_idx = cur_r[IW-1:0];
      malt_pkg::ST_AGE: rd_idx = age_idx_r;
      default: rd_idx = '0;
    endcase
    cur_e = tab_r[rd_idx];
    // Host make matches on the written address, not on the last packet
    hit_key = (state_r == malt_pkg::ST_MAKE) ? wr_e[MW-1:0] : sa_r;
    hit = cur_e[malt_pkg::B_VALID] && cur_e[MW-1:0] == ((state_r == malt_pkg::ST_LOOKUP) ? da_r : hit_key);
    learn_ok = (port_r < 2'(malt_pkg::N_PORTS)) && pcfg_r[port_r];
    state_nxt = state_r;
    sa_nxt = sa_r;
    da_nxt = da_r;
    port_nxt = port_r;
    cur_nxt = cur_r;
    age_idx_nxt = age_idx_r;
    rd_e_nxt = rd_e_r;
    eot_nxt = eot_r;
    tab_we = 1'b0;
    tab_widx = rd_idx;
    tab_wdata = '0;
    age_ack = 1'b0;
    lk_valid_nxt = 1'b0;
    lk_hit_nxt = lk_hit_r;
    lk_ports_nxt = lk_ports_r;
    lk_filter_nxt = lk_filter_r;
    lk_prio_nxt = lk_prio_r;
    lk_puse_nxt = lk_puse_r;
    lk_ovr_nxt = lk_ovr_r;
    // Set wins: a new make edge during the write re-arms the request
    make_pend_nxt = (make_pend_r && state_r != malt_pkg::ST_MAKE) || cmd_rise[malt_pkg::CMD_MAKE];
    walk_req_nxt = walk_req_r;
    case (state_r)
      malt_pkg::ST_IDLE: begin
        if (in_valid_i && in_ready_r) begin
          sa_nxt = in_sa_i;
          da_nxt = in_da_i;
          port_nxt = in_port_i;
          state_nxt = malt_pkg::ST_LOOKUP;
        end else if (make_pend_r) begin
          state_nxt = malt_pkg::ST_MAKE;
        end else if (walk_req_r) begin
          walk_req_nxt = 1'b0;
          state_nxt = malt_pkg::ST_WALK;
        end else if (age_if.req) begin
          state_nxt = malt_pkg::ST_AGE;
        end
      end
      malt_pkg::ST_LOOKUP: begin
        lk_valid_nxt = 1'b1;
        lk_hit_nxt = hit;
        lk_ports_nxt = hit ? cur_e[malt_pkg::B_PORT_HI:malt_pkg::B_PORT_LO] : 3'h0;
        lk_filter_nxt = hit && cur_e[malt_pkg::B_FILTER];
        lk_prio_nxt = hit ? cur_e[malt_pkg::B_PRIO_HI:malt_pkg::B_PRIO_LO] : 2'h0;
        lk_puse_nxt = hit && cur_e[malt_pkg::B_STATIC] && gcfg_r[malt_pkg::GCFG_DA_PRIO];
        lk_ovr_nxt = hit && cur_e[malt_pkg::B_STATIC] && cur_e[malt_pkg::B_AGE];
        state_nxt = malt_pkg::ST_LEARN;
      end
      malt_pkg::ST_LEARN: begin
        // Static slot is never touched; a learned slot of another address is replaced
        if (learn_ok && !(cur_e[malt_pkg::B_VALID] && cur_e[malt_pkg::B_STATIC])) begin
          tab_we = 1'b1;
          tab_wdata = hit ? cur_e : '0;
          tab_wdata[malt_pkg::B_VALID] = 1'b1;
          tab_wdata[malt_pkg::B_AGE] = 1'b1;
          tab_wdata[malt_pkg::B_PORT_HI:malt_pkg::B_PORT_LO] = 3'h1 << port_r;
          tab_wdata[MW-1:0] = sa_r;
        end
        state_nxt = malt_pkg::ST_IDLE;
      end
      malt_pkg::ST_MAKE: begin
        if (!wr_e[malt_pkg::B_VALID] && !wr_e[malt_pkg::B_STATIC]) begin
          tab_we = hit;
          tab_wdata = '0;
        end else begin
          tab_we = 1'b1;
          tab_wdata = wr_e;
        end
        state_nxt = malt_pkg::ST_IDLE;
      end
      malt_pkg::ST_WALK: begin
        // Walk follows index order, not learning order
        if (cur_r[IW]) begin
          eot_nxt = 1'b1;
          state_nxt = malt_pkg::ST_IDLE;
        end else if (cur_e[malt_pkg::B_VALID]) begin
          rd_e_nxt = cur_e;
          state_nxt = malt_pkg::ST_IDLE;
        end else begin
          cur_nxt = cur_r + 1'b1;
        end
      end
      malt_pkg::ST_AGE: begin
        if (cur_e[malt_pkg::B_VALID] && !cur_e[malt_pkg::B_STATIC]) begin
          tab_we = 1'b1;
          tab_wdata = cur_e[malt_pkg::B_AGE] ? cur_e & ~(EW'(1) << malt_pkg::B_AGE) : '0;
        end
        age_idx_nxt = age_idx_r + 1'b1;
        if (age_idx_r == IW'(malt_pkg::TAB_DEPTH - 1)) begin
          age_ack = 1'b1;
          state_nxt = malt_pkg::ST_IDLE;
        end
      end
      default: state_nxt = malt_pkg::ST_IDLE;
    endcase
    if (cmd_rise[malt_pkg::CMD_FIRST] || cmd_rise[malt_pkg::CMD_NEXT]) begin
      walk_req_nxt = 1'b1;
      rd_e_nxt = '0;
      eot_nxt = 1'b0;
      cur_nxt = cmd_rise[malt_pkg::CMD_FIRST] ? '0 : cur_r + 1'b1;
    end
    // Ready drops for one idle cycle after each packet so host work is not starved
    in_ready_nxt = (state_nxt == malt_pkg::ST_IDLE) && (state_r == malt_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_r <= malt_pkg::ST_IDLE;
      sa_r <= '0;
      da_r <= '0;
      port_r <= '0;
      in_ready_r <= 1'b0;
      make_pend_r <= 1'b0;
      walk_req_r <= 1'b0;
      cur_r <= '0;
      age_idx_r <= '0;
      rd_e_r <= '0;
      eot_r <= 1'b0;
      lk_valid_r <= 1'b0;
      lk_hit_r <= 1'b0;
      lk_ports_r <= '0;
      lk_filter_r <= 1'b0;
      lk_prio_r <= '0;
      lk_puse_r <= 1'b0;
      lk_ovr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      sa_r <= sa_nxt;
      da_r <= da_nxt;
      port_r <= port_nxt;
      in_ready_r <= in_ready_nxt;
      make_pend_r <= make_pend_nxt;
      walk_req_r <= walk_req_nxt;
      cur_r <= cur_nxt;
      age_idx_r <= age_idx_nxt;
      rd_e_r <= rd_e_nxt;
      eot_r <= eot_nxt;
      lk_valid_r <= lk_valid_nxt;
      lk_hit_r <= lk_hit_nxt;
      lk_ports_r <= lk_ports_nxt;
      lk_filter_r <= lk_filter_nxt;
      lk_prio_r <= lk_prio_nxt;
      lk_puse_r <= lk_puse_nxt;
      lk_ovr_r <= lk_ovr_nxt;
    end
  end

  assign age_if.ack = age_ack;
  assign in_ready_o = in_ready_r;
  assign lk_valid_o = lk_valid_r;
  assign lk_hit_o = lk_hit_r;
  assign lk_ports_o = lk_ports_r;
  assign lk_filter_o = lk_filter_r;
  assign lk_prio_o = lk_prio_r;
  assign lk_prio_use_o = lk_puse_r;
  assign lk_stp_override_o = lk_ovr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_lk_ports;
    (state_r == malt_pkg::ST_LOOKUP) && hit |=> lk_valid_o && lk_hit_o
      && lk_ports_o == $past(cur_e[malt_pkg::B_PORT_HI:malt_pkg::B_PORT_LO]);
  endproperty
  a_lk_ports: assert property (p_lk_ports) else $error("lookup result not from matching entry");
  property p_lk_ovr;
    (state_r == malt_pkg::ST_LOOKUP) |=> lk_stp_override_o == $past(hit && cur_e[malt_pkg::B_STATIC]
      && cur_e[malt_pkg::B_AGE]);
  endproperty
  a_lk_ovr: assert property (p_lk_ovr) else $error("override flag wrong");
  property p_lk_puse;
    lk_valid_o && lk_prio_use_o |-> lk_hit_o && $past(gcfg_r[malt_pkg::GCFG_DA_PRIO]);
  endproperty
  a_lk_puse: assert property (p_lk_puse) else $error("priority use without enable or hit");
  property p_learn_off;
    (state_r == malt_pkg::ST_LEARN) && !learn_ok |-> !tab_we;
  endproperty
  a_learn_off: assert property (p_learn_off) else $error("learning on disabled port");
  property p_learn_new;
    (state_r == malt_pkg::ST_LEARN) && learn_ok && !cur_e[malt_pkg::B_VALID]
      |=> tab_r[$past(rd_idx)][MW-1:0] == $past(sa_r) && tab_r[$past(rd_idx)][malt_pkg::B_VALID];
  endproperty
  a_learn_new: assert property (p_learn_new) else $error("unknown source not learned");
  property p_static_kept;
    tab_we && (state_r == malt_pkg::ST_LEARN || state_r == malt_pkg::ST_AGE)
      |-> !(cur_e[malt_pkg::B_VALID] && cur_e[malt_pkg::B_STATIC]);
  endproperty
  a_static_kept: assert property (p_static_kept) else $error("static entry changed");
  property p_age_remove;
    (state_r == malt_pkg::ST_AGE) && cur_e[malt_pkg::B_VALID] && !cur_e[malt_pkg::B_STATIC]
      && !cur_e[malt_pkg::B_AGE] |=> !tab_r[$past(rd_idx)][malt_pkg::B_VALID];
  endproperty
  a_age_remove: assert property (p_age_remove) else $error("stale entry not removed");
  // Cycles spent with a make request pending
  logic [10:0] make_wait_r;
  logic [10:0] make_wait_nxt;
  always_comb begin
    make_wait_nxt = make_pend_r ? make_wait_r + 11'h001 : 11'h000;
  end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      make_wait_r <= 11'h000;
    end else begin
      make_wait_r <= make_wait_nxt;
    end
  end
  property p_make_done;
    make_pend_r |-> make_wait_r < malt_pkg::MAKE_MAX_CYC;
  endproperty
  a_make_done: assert property (p_make_done) else $error("make pending never clears");
  property p_cmd_level;
    $fell(make_pend_r) && cmd_r[malt_pkg::CMD_MAKE] ##1 cmd_r[malt_pkg::CMD_MAKE] |=> !make_pend_r;
  endproperty
  a_cmd_level: assert property (p_cmd_level) else $error("held command repeated");
  property p_walk_start;
    cmd_rise[malt_pkg::CMD_FIRST] |=> !rd_e_r[malt_pkg::B_VALID] && !eot_r && cur_r == '0;
  endproperty
  a_walk_start: assert property (p_walk_start) else $error("get first did not restart walk");

  c_make: cover property ($fell(make_pend_r));
  c_eot: cover property ($rose(eot_r));
  c_learn: cover property ((state_r == malt_pkg::ST_LEARN) && tab_we);
  c_age_rm: cover property ((state_r == malt_pkg::ST_AGE) && tab_we && tab_wdata == '0);

endmodule : malt_engine

// File: design/malt_pkg.sv
// Purpose: Shared constants, types and helpers of the MAC address table
// Assumes: 20 MHz clock, byte-addressed Avalon-MM register window
// Notes: Entry layout, register map and command codes live here only
package malt_pkg;

  localparam int unsigned TAB_DEPTH = 1024;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned ENT_W = 57;
  localparam int unsigned MAC_W = 48;
  localparam int unsigned HI_W = 25;
  localparam int unsigned N_PORTS = 3;

  // ----------------------------------------------------------------
  // Table entry fields
  // ----------------------------------------------------------------
  localparam int unsigned B_VALID = 56;
  localparam int unsigned B_AGE = 55;
  localparam int unsigned B_STATIC = 54;
  localparam int unsigned B_FILTER = 53;
  localparam int unsigned B_PRIO_HI = 52;
  localparam int unsigned B_PRIO_LO = 51;
  localparam int unsigned B_PORT_HI = 50;
  localparam int unsigned B_PORT_LO = 48;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CMD = 5'h00;
  localparam logic [4:0] OFF_STS = 5'h04;
  localparam logic [4:0] OFF_WR_LO = 5'h08;
  localparam logic [4:0] OFF_WR_HI = 5'h0C;
  localparam logic [4:0] OFF_RD_LO = 5'h10;
  localparam logic [4:0] OFF_RD_HI = 5'h14;
  localparam logic [4:0] OFF_GCFG = 5'h18;
  localparam logic [4:0] OFF_PCFG = 5'h1C;
  localparam int unsigned CMD_NEXT = 0;
  localparam int unsigned CMD_FIRST = 1;
  localparam int unsigned CMD_MAKE = 2;
  localparam int unsigned RD_EOT = 25;
  localparam int unsigned GCFG_DA_PRIO = 0;
  localparam logic [2:0] PCFG_RST = 3'h7;

  // ----------------------------------------------------------------
  // Aging period
  // ----------------------------------------------------------------
  localparam longint unsigned AGE_PERIOD_S = 64'h0000_0000_0000_012C;
  localparam longint unsigned CLK_HZ = 64'h0000_0000_0131_2D00;
  localparam longint unsigned AGE_CYCLES = AGE_PERIOD_S * CLK_HZ;
  localparam int unsigned AGE_CNT_W = 33;
  // Longest wait for a make entry: one full aging scan plus the write
  localparam logic [10:0] MAKE_MAX_CYC = 11'h44C;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOOKUP = 6'h02,
    ST_LEARN = 6'h04,
    ST_MAKE = 6'h08,
    ST_WALK = 6'h10,
    ST_AGE = 6'h20
  } malt_state_e;

  // Folds a MAC address onto a table index
  function automatic logic [IDX_W-1:0] malt_hash(input logic [MAC_W-1:0] mac);
    malt_hash = mac[9:0] ^ mac[19:10] ^ mac[29:20] ^ mac[39:30] ^ {2'h0, mac[47:40]};
  endfunction : malt_hash

  function automatic logic [31:0] malt_be_merge(input logic [31:0] old, input logic [31:0] wd,
                                                input logic [3:0] be);
    malt_be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        malt_be_merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction : malt_be_merge

endpackage : malt_pkg

// File: test/malt_ingress_src.sv
// Purpose: Ingress datapath model feeding packet descriptors
// Assumes: One clock; result captured on the lookup pulse
// Notes: Address lines carry inverted data between descriptors
`timescale 1ns/100ps
module malt_ingress_src (
  input wire logic mclk_i,
  input wire logic in_ready_i,
  input wire logic lk_valid_i,
  input wire logic [8:0] lk_res_i,
  output logic in_valid_o,
  output logic [47:0] in_sa_o,
  output logic [47:0] in_da_o,
  output logic [1:0] in_port_o
);
  logic [8:0] res;
  initial begin
    in_valid_o = 1'b0;
    in_sa_o = 48'h0;
    in_da_o = 48'h0;
    in_port_o = 2'h3;
    res = 9'h0;
  end
  task automatic send(input logic [47:0] sa, input logic [47:0] da, input logic [1:0] pt);
    @(posedge mclk_i);
    in_valid_o <= 1'b1;
    in_sa_o <= sa;
    in_da_o <= da;
    in_port_o <= pt;
    do @(posedge mclk_i); while (in_ready_i !== 1'b1);
    in_valid_o <= 1'b0;
    // Stale addresses must not pass for a held descriptor
    in_sa_o <= ~sa;
    in_da_o <= ~da;
    do @(posedge mclk_i); while (lk_valid_i !== 1'b1);
    res = lk_res_i;
  endtask : send
endmodule : malt_ingress_src

// File: test/tb_malt_engine.sv
// Purpose: Self-checking bench of the MAC address table
// Assumes: Aging period shortened to 3000 cycles
// Notes: Probes use port 3 so they never learn
`timescale 1ns/100ps
`define CK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_malt_engine;
  logic mclk_i, srst_i, rd, wr, wt, iv, ir, lv, hit, flt, pu, so;
  logic [4:0] adr;
  logic [31:0] wd, rdat, q, lo, hi;
  logic [47:0] sa, da;
  logic [1:0] pt, pr;
  logic [2:0] pm;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  localparam logic [56:0] EC = {4'hF, 2'h2, 3'h5, 48'h22};
  localparam logic [56:0] ED = {4'hA, 2'h1, 3'h3, 48'h33};
  localparam logic [8:0] HC = {1'b1, 3'h5, 1'b1, 2'h2, 2'h3};
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    srst_i = 1'b1;
    {rd, wr, adr, wd} = '0;
  end
  malt_engine #(.P_AGE_CYCLES(33'h0_0000_0BB8)) DUT (.mclk_i(mclk_i), .srst_i(srst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .in_valid_i(iv),
    .in_ready_o(ir), .in_sa_i(sa), .in_da_i(da), .in_port_i(pt), .lk_valid_o(lv), .lk_hit_o(hit),
    .lk_ports_o(pm), .lk_filter_o(flt), .lk_prio_o(pr), .lk_prio_use_o(pu), .lk_stp_override_o(so));
  malt_ingress_src u_src (.mclk_i(mclk_i), .in_ready_i(ir), .lk_valid_i(lv),
    .lk_res_i({hit, pm, flt, pr, pu, so}), .in_valid_o(iv), .in_sa_o(sa), .in_da_o(da), .in_port_o(pt));
  // ----------------------------------------------------------------
  // Bus and table helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    do @(posedge mclk_i); while (wt !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic make(input logic [56:0] e);
    logic [31:0] r;
    bus(1'b1, malt_pkg::OFF_WR_LO, e[31:0], r);
    bus(1'b1, malt_pkg::OFF_WR_HI, {7'h00, e[56:32]}, r);
    bus(1'b1, malt_pkg::OFF_CMD, 32'h0000_0004, r);
    // Pending is up by the time the first status read is sampled
    bus(1'b0, malt_pkg::OFF_STS, 32'h0, r);
    `CK(r[0], 1'b1)
    do bus(1'b0, malt_pkg::OFF_STS, 32'h0, r); while (r[0] !== 1'b0);
    bus(1'b1, malt_pkg::OFF_CMD, 32'h0, r);
  endtask : make
  task automatic walk(input logic [31:0] c);
    bus(1'b1, malt_pkg::OFF_CMD, c, lo);
    bus(1'b1, malt_pkg::OFF_CMD, 32'h0, lo);
    do bus(1'b0, malt_pkg::OFF_RD_HI, 32'h0, hi); while (hi[25:24] === 2'h0);
    bus(1'b0, malt_pkg::OFF_RD_LO, 32'h0, lo);
  endtask : walk
  task automatic probe(input logic [47:0] a, input logic [8:0] e);
    u_src.send(48'h0, a, 2'h3);
    `CK(u_src.res, e)
  endtask : probe
  task automatic complete_run();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 25000) begin
      bad_count++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    srst_i <= 1'b0;
    bus(1'b0, malt_pkg::OFF_GCFG, 32'h0, q);
    `CK(q[0], 1'b0)
    bus(1'b0, malt_pkg::OFF_PCFG, 32'h0, q);
    `CK(q[2:0], 3'h7)
    u_src.send(48'h11, 48'h55, 2'h1);
    `CK(u_src.res, 9'h000)
    probe(48'h11, {1'b1, 3'h2, 5'h00});
    u_src.send(48'h11, 48'h55, 2'h2);
    probe(48'h11, {1'b1, 3'h4, 5'h00});
    bus(1'b1, malt_pkg::OFF_PCFG, 32'h0000_0003, q);
    u_src.send(48'h44, 48'h55, 2'h2);
    probe(48'h44, 9'h000);
    bus(1'b1, malt_pkg::OFF_PCFG, 32'h0000_0007, q);
    bus(1'b1, malt_pkg::OFF_GCFG, 32'h0000_0001, q);
    make(EC);
    probe(48'h22, HC);
    u_src.send(48'h22, 48'h55, 2'h0);
    probe(48'h22, HC);
    repeat (2900) @(posedge mclk_i);
    probe(48'h11, {1'b1, 3'h4, 5'h00});
    repeat (3400) @(posedge mclk_i);
    probe(48'h11, 9'h000);
    probe(48'h22, HC);
    make({9'h000, 48'h22});
    probe(48'h22, 9'h000);
    make(ED);
    walk(32'h0000_0002);
    `CK(hi, {7'h00, ED[56:32]})
    `CK(lo, ED[31:0])
    walk(32'h0000_0001);
    `CK(hi[25:24], 2'h2)
    complete_run();
  end
endmodule : tb_malt_engine
